//--- verilog/smt_regs.svh
`ifndef SMT_REGS_SVH
`define SMT_REGS_SVH

// Byte register offsets of the indirect access window.
`define SMT_OFF_CTL        8'h79
`define SMT_OFF_ADDR_LO    8'h7A
`define SMT_OFF_DATA8      8'h7B
`define SMT_OFF_DATA7      8'h7C
`define SMT_OFF_DATA6      8'h7D
`define SMT_OFF_DATA5      8'h7E
`define SMT_OFF_DATA4      8'h7F
`define SMT_OFF_DATA3      8'h80
`define SMT_OFF_DATA2      8'h81
`define SMT_OFF_DATA1      8'h82
`define SMT_OFF_DATA0      8'h83
`define SMT_OFF_TST_DSTAT  8'h84
`define SMT_OFF_TST_DCTL   8'h85
`define SMT_OFF_TST_ACTLA  8'h86
`define SMT_OFF_TST_ACTLB  8'h87
`define SMT_OFF_TST_ACTLC  8'h88
`define SMT_OFF_TST_ACTLD  8'h89
`define SMT_OFF_TST_ASTAT  8'h8A
`define SMT_OFF_TST_ACTLE  8'h8B
`define SMT_OFF_TST_QDLO   8'h8C
`define SMT_OFF_TST_QDHI   8'h8D

// Control register fields.
`define SMT_CTL_RD_BIT     4
`define SMT_CTL_TSEL_HI    3
`define SMT_CTL_TSEL_LO    2
`define SMT_CTL_IDXH_HI    1
`define SMT_CTL_TSEL_STATIC 2'h0

// Entry fields.
`define SMT_ENT_W          58
`define SMT_ENT_FID_HI     57
`define SMT_ENT_FID_LO     54
`define SMT_ENT_USEFID     53
`define SMT_ENT_OVERRIDE   52
`define SMT_ENT_VALID      51
`define SMT_ENT_PORTS_HI   50
`define SMT_ENT_PORTS_LO   48
`define SMT_ENT_ADDR_HI    47
`define SMT_ENT_DEPTH      8
`define SMT_PORTS_ALL      3'h7

// Reset values.
`define SMT_RST_BYTE       8'h00
`define SMT_RST_DCTL       8'h3F
`define SMT_RST_ACTLE      8'h40

`endif

//--- verilog/smt_pkg.sv
package smt_pkg;

  typedef enum logic [1:0]
  {
    SMT_ST_IDLE = 2'h1,
    SMT_ST_RDLD = 2'h2
  } smt_state_t;

  typedef logic [57:0] smt_entry_t;

endpackage : smt_pkg

//--- verilog/smt_entry_mem.sv
`timescale 1ns/1ns
`include "smt_regs.svh"
module smt_entry_mem
  import smt_pkg::*;
#(
  parameter int DEPTH = `SMT_ENT_DEPTH
)
(
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rst,
  input  wire logic                     ce,
  // Host port
  input  wire logic                     wr_en,
  input  wire logic                     rd_en,
  input  wire logic [$clog2(DEPTH)-1:0] acc_idx,
  input  wire smt_entry_t               wr_data,
  output smt_entry_t                    rd_data,
  // Destination lookup key
  input  wire logic [47:0]              key_addr,
  input  wire logic [3:0]               key_fid,
  output logic                          hit,
  output smt_entry_t                    hit_entry
);

  smt_entry_t mem [DEPTH];
  smt_entry_t next_mem [DEPTH];
  smt_entry_t next_rd_data;
  logic       next_hit;
  smt_entry_t next_hit_entry;

  function automatic logic entry_match(smt_entry_t e, logic [47:0] a,
                                       logic [3:0] f);
    logic fid_ok;
    fid_ok = !e[`SMT_ENT_USEFID] ||
             (e[`SMT_ENT_FID_HI:`SMT_ENT_FID_LO] == f);
    return e[`SMT_ENT_VALID] && fid_ok &&
           (e[`SMT_ENT_ADDR_HI:0] == a);
  endfunction : entry_match

  // Only the host port writes; entries never age or clear on their own.
  always_comb
  begin
    next_mem = mem;
    next_rd_data = rd_data;
    next_hit = 1'b0;
    next_hit_entry = '0;
    if (wr_en)
    begin
      next_mem[acc_idx] = wr_data;
    end
    if (rd_en)
    begin
      next_rd_data = mem[acc_idx];
    end
    // Lowest index wins if the host programmed duplicates.
    for (int i = DEPTH - 1; i >= 0; i--)
    begin
      if (entry_match(mem[i], key_addr, key_fid))
      begin
        next_hit = 1'b1;
        next_hit_entry = mem[i];
      end
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem[i] <= '0;
      end
      rd_data <= '0;
      hit <= 1'b0;
      hit_entry <= '0;
    end
    else if (ce)
    begin
      mem <= next_mem;
      rd_data <= next_rd_data;
      hit <= next_hit;
      hit_entry <= next_hit_entry;
    end
  end

endmodule : smt_entry_mem

//--- verilog/smt_fwd_decide.sv
`timescale 1ns/1ns
`include "smt_regs.svh"
module smt_fwd_decide
  import smt_pkg::*;
(
  // Static result
  input  wire logic       st_hit,
  input  wire smt_entry_t st_entry,
  // Dynamic result and port state
  input  wire logic       dyn_hit,
  input  wire logic [2:0] dyn_ports,
  input  wire logic [2:0] ingress,
  input  wire logic [2:0] tx_en,
  input  wire logic [2:0] rx_en,
  // Decision
  output logic [2:0]      ports,
  output logic            from_static,
  output logic            from_dyn
);

  logic [2:0] mask;
  logic       ovr;

  always_comb
  begin
    mask = st_entry[`SMT_ENT_PORTS_HI:`SMT_ENT_PORTS_LO];
    ovr = st_hit && st_entry[`SMT_ENT_OVERRIDE];
    from_static = st_hit;
    from_dyn = dyn_hit && !st_hit;
    ports = 3'h0;
    if (st_hit)
    begin
      if (mask == `SMT_PORTS_ALL)
      begin
        ports = ~ingress;
      end
      else
      begin
        ports = mask;
      end
    end
    else if (dyn_hit)
    begin
      ports = dyn_ports;
    end
    if (!ovr)
    begin
      ports = ports & tx_en;
      if ((ingress & rx_en) == 3'h0)
      begin
        ports = 3'h0;
      end
    end
  end

endmodule : smt_fwd_decide

//--- verilog/smt_table.sv
`timescale 1ns/1ns
`include "smt_regs.svh"
module smt_table
  import smt_pkg::*;
#(
  parameter int DEPTH = `SMT_ENT_DEPTH
)
(
  // Clock, reset and enable
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Byte register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  output logic             acc_busy,
  // Destination lookup request
  input  wire logic        lk_req,
  input  wire logic [47:0] lk_dest_station_addr,
  input  wire logic [3:0]  lk_filter_group_id,
  input  wire logic [2:0]  lk_ingress,
  input  wire logic        dyn_hit,
  input  wire logic [2:0]  dyn_ports,
  input  wire logic [2:0]  port_tx_en,
  input  wire logic [2:0]  port_rx_en,
  // Forwarding decision
  output logic             fwd_valid,
  output logic [2:0]       fwd_ports,
  output logic             fwd_static_hit,
  output logic             fwd_dyn_hit
);

  localparam int IW = $clog2(DEPTH);

  smt_state_t state;
  smt_state_t next_state;
  logic [7:0] ctl;
  logic [7:0] next_ctl;
  logic [7:0] addr_lo;
  logic [7:0] next_addr_lo;
  smt_entry_t data;
  smt_entry_t next_data;
  logic [7:0] tst [6];
  logic [7:0] next_tst [6];
  logic [7:0] next_reg_rdata;
  logic       next_acc_busy;
  logic       mem_wr;
  logic       mem_rd;
  logic [9:0] acc_full_idx;
  logic [IW-1:0] acc_idx;
  smt_entry_t mem_rdata;
  logic       st_hit;
  smt_entry_t st_entry;

  // Lookup pipeline stage aligned with the registered static match.
  logic       s1_valid;
  logic [2:0] s1_ingress;
  logic       s1_dyn_hit;
  logic [2:0] s1_dyn_ports;
  logic [2:0] s1_tx;
  logic [2:0] s1_rx;
  logic [2:0] dec_ports;
  logic       dec_static;
  logic       dec_dyn;

  // Byte view of the entry buffer. Offset 0x7C keeps only bits 57:56.
  // Reserved and test offsets fall to the default, so writes there leave
  // the buffer unchanged and the lane read gives zero.
  function automatic smt_entry_t lane_wr(smt_entry_t d, logic [7:0] a,
                                         logic [7:0] v);
    smt_entry_t n;
    n = d;
    case (a)
      `SMT_OFF_DATA7: n[57:56] = v[1:0];
      `SMT_OFF_DATA6: n[55:48] = v;
      `SMT_OFF_DATA5: n[47:40] = v;
      `SMT_OFF_DATA4: n[39:32] = v;
      `SMT_OFF_DATA3: n[31:24] = v;
      `SMT_OFF_DATA2: n[23:16] = v;
      `SMT_OFF_DATA1: n[15:8] = v;
      `SMT_OFF_DATA0: n[7:0] = v;
      default:        n = d;
    endcase
    return n;
  endfunction : lane_wr

  function automatic logic [7:0] lane_rd(smt_entry_t d, logic [7:0] a);
    logic [7:0] b;
    b = 8'h00;
    case (a)
      `SMT_OFF_DATA7: b = {6'h00, d[57:56]};
      `SMT_OFF_DATA6: b = d[55:48];
      `SMT_OFF_DATA5: b = d[47:40];
      `SMT_OFF_DATA4: b = d[39:32];
      `SMT_OFF_DATA3: b = d[31:24];
      `SMT_OFF_DATA2: b = d[23:16];
      `SMT_OFF_DATA1: b = d[15:8];
      `SMT_OFF_DATA0: b = d[7:0];
      default:        b = 8'h00;
    endcase
    return b;
  endfunction : lane_rd

  // The match is registered inside the memory, which costs one cycle of
  // lookup latency but keeps the eight wide compares off the output path.
  smt_entry_mem #(
    .DEPTH (DEPTH)
  ) u_mem (
    .mclk      (mclk),
    .rst       (rst),
    .ce        (ce),
    .wr_en     (mem_wr),
    .rd_en     (mem_rd),
    .acc_idx   (acc_idx),
    .wr_data   (data),
    .rd_data   (mem_rdata),
    .key_addr  (lk_dest_station_addr),
    .key_fid   (lk_filter_group_id),
    .hit       (st_hit),
    .hit_entry (st_entry)
  );

  smt_fwd_decide u_dec (
    .st_hit      (st_hit),
    .st_entry    (st_entry),
    .dyn_hit     (s1_dyn_hit),
    .dyn_ports   (s1_dyn_ports),
    .ingress     (s1_ingress),
    .tx_en       (s1_tx),
    .rx_en       (s1_rx),
    .ports       (dec_ports),
    .from_static (dec_static),
    .from_dyn    (dec_dyn)
  );

  // The index uses the byte being written to the address-low register.
  always_comb
  begin
    acc_full_idx = {ctl[`SMT_CTL_IDXH_HI:0], reg_wdata};
    acc_idx = acc_full_idx[IW-1:0];
  end

  // Register file and indirect access sequencing.
  always_comb
  begin
    next_state = state;
    next_ctl = ctl;
    next_addr_lo = addr_lo;
    next_data = data;
    next_tst = tst;
    next_reg_rdata = reg_rdata;
    mem_wr = 1'b0;
    mem_rd = 1'b0;
    // The byte port is the only way in; lookups never write the table.
    if (reg_wr)
    begin
      next_data = lane_wr(data, reg_addr, reg_wdata);
      case (reg_addr)
        `SMT_OFF_CTL:     next_ctl = reg_wdata;
        `SMT_OFF_ADDR_LO:
        begin
          next_addr_lo = reg_wdata;
          // Other tables and out-of-range indices belong elsewhere.
          if (ctl[`SMT_CTL_TSEL_HI:`SMT_CTL_TSEL_LO] ==
              `SMT_CTL_TSEL_STATIC && acc_full_idx < 10'(DEPTH))
          begin
            if (ctl[`SMT_CTL_RD_BIT])
            begin
              mem_rd = 1'b1;
              next_state = SMT_ST_RDLD;
            end
            else
            begin
              mem_wr = 1'b1;
            end
          end
        end
        `SMT_OFF_TST_DCTL:  next_tst[0] = reg_wdata;
        `SMT_OFF_TST_ACTLA: next_tst[1] = reg_wdata;
        `SMT_OFF_TST_ACTLB: next_tst[2] = reg_wdata;
        `SMT_OFF_TST_ACTLC: next_tst[3] = reg_wdata;
        `SMT_OFF_TST_ACTLD: next_tst[4] = reg_wdata;
        `SMT_OFF_TST_ACTLE: next_tst[5] = reg_wdata;
        default:          next_ctl = ctl;
      endcase
    end
    case (state)
      SMT_ST_RDLD:
      begin
        // The entry load wins over a host data write in the same cycle.
        next_data = mem_rdata;
        next_state = SMT_ST_IDLE;
      end
      SMT_ST_IDLE: next_state = next_state;
      default:     next_state = SMT_ST_IDLE;
    endcase
    if (reg_rd)
    begin
      case (reg_addr)
        `SMT_OFF_CTL:       next_reg_rdata = ctl;
        `SMT_OFF_ADDR_LO:   next_reg_rdata = addr_lo;
        `SMT_OFF_TST_DCTL:  next_reg_rdata = tst[0];
        `SMT_OFF_TST_ACTLA: next_reg_rdata = tst[1];
        `SMT_OFF_TST_ACTLB: next_reg_rdata = tst[2];
        `SMT_OFF_TST_ACTLC: next_reg_rdata = tst[3];
        `SMT_OFF_TST_ACTLD: next_reg_rdata = tst[4];
        `SMT_OFF_TST_ACTLE: next_reg_rdata = tst[5];
        default:            next_reg_rdata = lane_rd(data, reg_addr);
      endcase
    end
    next_acc_busy = (next_state == SMT_ST_RDLD);
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state <= SMT_ST_IDLE;
      ctl <= `SMT_RST_BYTE;
      addr_lo <= `SMT_RST_BYTE;
      data <= '0;
      tst[0] <= `SMT_RST_DCTL;
      tst[1] <= `SMT_RST_BYTE;
      tst[2] <= `SMT_RST_BYTE;
      tst[3] <= `SMT_RST_BYTE;
      tst[4] <= `SMT_RST_BYTE;
      tst[5] <= `SMT_RST_ACTLE;
      reg_rdata <= 8'h00;
      acc_busy <= 1'b0;
    end
    else if (ce)
    begin
      state <= next_state;
      ctl <= next_ctl;
      addr_lo <= next_addr_lo;
      data <= next_data;
      tst <= next_tst;
      reg_rdata <= next_reg_rdata;
      acc_busy <= next_acc_busy;
    end
  end

  // Lookup pipeline: static match registers in the memory, the rest here.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s1_valid <= 1'b0;
      s1_ingress <= 3'h0;
      s1_dyn_hit <= 1'b0;
      s1_dyn_ports <= 3'h0;
      s1_tx <= 3'h0;
      s1_rx <= 3'h0;
      fwd_valid <= 1'b0;
      fwd_ports <= 3'h0;
      fwd_static_hit <= 1'b0;
      fwd_dyn_hit <= 1'b0;
    end
    else if (ce)
    begin
      s1_valid <= lk_req;
      s1_ingress <= lk_ingress;
      s1_dyn_hit <= dyn_hit;
      s1_dyn_ports <= dyn_ports;
      s1_tx <= port_tx_en;
      s1_rx <= port_rx_en;
      fwd_valid <= s1_valid;
      fwd_ports <= s1_valid ? dec_ports : 3'h0;
      fwd_static_hit <= s1_valid && dec_static;
      fwd_dyn_hit <= s1_valid && dec_dyn;
    end
  end

endmodule : smt_table

//--- dv/smt_table_chk.sv
`timescale 1ns/1ns
module smt_table_chk
(
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       ce,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       acc_busy,
  // Lookup
  input wire logic       lk_req,
  input wire logic [2:0] lk_ingress,
  input wire logic       dyn_hit,
  input wire logic [2:0] dyn_ports,
  input wire logic [2:0] port_tx_en,
  input wire logic [2:0] port_rx_en,
  input wire logic       fwd_valid,
  input wire logic [2:0] fwd_ports,
  input wire logic       fwd_static_hit,
  input wire logic       fwd_dyn_hit
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_lookup_latency: assert property (lk_req && ce ##1 ce |=> fwd_valid)
    else $error("lookup answer missing");
  a_answer_origin: assert property (fwd_valid |-> $past(lk_req && ce, 2))
    else $error("answer without request");
  a_static_wins: assert property (!(fwd_static_hit && fwd_dyn_hit))
    else $error("both hit flags set");
  a_idle_quiet: assert property (!fwd_valid |-> fwd_ports == 3'h0
    && !fwd_static_hit && !fwd_dyn_hit) else $error("decision outside answer");
  a_dyn_follows: assert property (fwd_valid && !fwd_static_hit
    |-> fwd_dyn_hit == $past(dyn_hit, 2)) else $error("dynamic hit wrong");
  a_dyn_ports: assert property (fwd_dyn_hit |-> fwd_ports ==
    ((|($past(port_rx_en, 2) & $past(lk_ingress, 2))) ?
    $past(dyn_ports, 2) & $past(port_tx_en, 2) : 3'h0))
    else $error("dynamic ports wrong");
  a_busy_cause: assert property ($rose(acc_busy)
    |-> $past(reg_wr && ce && reg_addr == 8'h7A)) else $error("busy cause");
  a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved");

  c_static: cover property (fwd_valid && fwd_static_hit);
  c_dyn: cover property (fwd_valid && fwd_dyn_hit);
  c_busy: cover property (acc_busy);
endmodule : smt_table_chk

bind smt_table smt_table_chk u_chk (.mclk, .rst, .ce, .reg_addr, .reg_wr,
  .reg_rd, .reg_rdata, .acc_busy, .lk_req, .lk_ingress, .dyn_hit, .dyn_ports,
  .port_tx_en, .port_rx_en, .fwd_valid, .fwd_ports, .fwd_static_hit,
  .fwd_dyn_hit);

//--- dv/smt_host_model.sv
`timescale 1ns/1ns
module smt_host_model
(
  // Clock
  input wire logic       mclk,
  // Register port
  output logic [7:0]     reg_addr,
  output logic [7:0]     reg_wdata,
  output logic           reg_wr,
  output logic           reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // Released lines show inverted data so stale values never look valid.
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : wr

  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(negedge mclk);
    d = reg_rdata;
  endtask : rd
endmodule : smt_host_model

//--- dv/static_mac_table_lookup_tb_top.sv
`timescale 1ns/1ns
module static_mac_table_lookup_tb_top
  import smt_pkg::*;
;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        lk_req = 1'b0;
  logic [47:0] lk_addr = '0;
  logic [3:0]  lk_fid = '0;
  logic        dyn_hit = 1'b0;
  logic [2:0]  dyn_ports = '0;
  logic [2:0]  tx_en = 3'h7;
  logic [2:0]  ingress = 3'h1;
  logic [2:0]  rx_en = 3'h7;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic        reg_wr, reg_rd, acc_busy;
  logic        fwd_valid, fwd_static_hit, fwd_dyn_hit;
  logic [2:0]  fwd_ports;
  int          n_errors = 0;
  int          n_tests = 0;
  int          cyc = 0;

  always #5 mclk = ~mclk;

  smt_host_model u_host (.mclk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata);

  smt_table #(.DEPTH(8)) DUT (.mclk, .rst, .ce, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .acc_busy, .lk_req,
    .lk_dest_station_addr(lk_addr), .lk_filter_group_id(lk_fid),
    .lk_ingress(ingress), .dyn_hit, .dyn_ports, .port_tx_en(tx_en),
    .port_rx_en(rx_en), .fwd_valid, .fwd_ports, .fwd_static_hit,
    .fwd_dyn_hit);

  task report_and_stop();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      report_and_stop();
    end
  end

  task chk(input logic [63:0] g, input logic [63:0] e);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  function automatic smt_entry_t mk(logic [3:0] f, logic [2:0] c,
                                    logic [2:0] m, logic [47:0] a);
    return {f, c, m, a};
  endfunction : mk

  task put(input logic [2:0] i, input smt_entry_t e);
    for (int k = 0; k < 8; k++)
      u_host.wr(8'h7C + 8'(k), 8'(e >> (8 * (7 - k))));
    u_host.wr(8'h79, 8'h00);
    u_host.wr(8'h7A, {5'h0, i});
  endtask : put

  task get(input logic [2:0] i, output smt_entry_t e);
    logic [7:0] b;
    e = '0;
    u_host.wr(8'h79, 8'h10);
    u_host.wr(8'h7A, {5'h0, i});
    @(negedge mclk);
    chk(acc_busy, 1'b1);
    for (int k = 0; k < 8; k++)
    begin
      u_host.rd(8'h7C + 8'(k), b);
      e = {e[49:0], b};
    end
  endtask : get

  // Expected word is {ports, static hit, dynamic hit}.
  task lk(input logic [47:0] a, input logic [3:0] f, input logic [2:0] t,
          input logic [2:0] dp, input logic d, input logic [4:0] x);
    @(posedge mclk);
    lk_req <= 1'b1;
    lk_addr <= a;
    lk_fid <= f;
    tx_en <= t;
    dyn_ports <= dp;
    dyn_hit <= d;
    @(posedge mclk);
    lk_req <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
    chk({fwd_valid, fwd_ports, fwd_static_hit, fwd_dyn_hit}, {1'b1, x});
  endtask : lk

  task t_regs();
    logic [7:0] b;
    logic [7:0] ad [7] = '{8'h7F, 8'h83, 8'h84, 8'h85, 8'h8B, 8'h8D, 8'h00};
    logic [7:0] ex [7] = '{8'h00, 8'h00, 8'h00, 8'h3F, 8'h40, 8'h00, 8'h00};
    for (int k = 0; k < 7; k++)
    begin
      u_host.rd(ad[k], b);
      chk(b, ex[k]);
    end
    for (int k = 0; k < 5; k++)
      u_host.wr(8'h7F + 8'(k), 8'hA0 + 8'(k));
    for (int k = 0; k < 5; k++)
    begin
      u_host.rd(8'h7F + 8'(k), b);
      chk(b, 8'hA0 + 8'(k));
    end
    $display("t_regs done");
  endtask : t_regs

  task t_entries();
    smt_entry_t e;
    put(0, mk(4'h0, 3'b001, 3'b111, 48'hA));
    put(1, mk(4'h5, 3'b101, 3'b010, 48'hB));
    put(2, mk(4'h0, 3'b000, 3'b001, 48'hC));
    put(3, mk(4'h0, 3'b011, 3'b101, 48'hD));
    put(7, mk(4'hC, 3'b111, 3'b110, 48'hFEDC_BA98_7654));
    get(1, e);
    chk(e, mk(4'h5, 3'b101, 3'b010, 48'hB));
    get(7, e);
    chk(e, mk(4'hC, 3'b111, 3'b110, 48'hFEDC_BA98_7654));
    $display("t_entries done");
  endtask : t_entries

  task t_lookup();
    lk(48'hA, 4'h3, 3'h7, 3'h1, 1'b1, {3'b110, 2'b10});
    lk(48'hA, 4'h0, 3'h3, 3'h0, 1'b0, {3'b010, 2'b10});
    lk(48'hB, 4'h5, 3'h7, 3'h4, 1'b1, {3'b010, 2'b10});
    lk(48'hB, 4'h4, 3'h7, 3'h4, 1'b1, {3'b100, 2'b01});
    lk(48'hC, 4'h0, 3'h7, 3'h0, 1'b0, {3'b000, 2'b00});
    lk(48'hD, 4'h0, 3'h0, 3'h0, 1'b0, {3'b101, 2'b10});
    $display("t_lookup done");
  endtask : t_lookup

  task t_masks();
    for (int m = 1; m < 7; m++)
    begin
      put(4, mk(4'h0, 3'b001, 3'(m), 48'hE));
      lk(48'hE, 4'h0, 3'h7, 3'h0, 1'b0, {3'(m), 2'b10});
    end
    $display("t_masks done");
  endtask : t_masks

  task t_ports();
    @(posedge mclk);
    ingress <= 3'h2;
    lk(48'hA, 4'h0, 3'h7, 3'h0, 1'b0, {3'b101, 2'b10});
    @(posedge mclk);
    rx_en <= 3'h5;
    lk(48'hB, 4'h5, 3'h7, 3'h0, 1'b0, {3'b000, 2'b10});
    lk(48'hD, 4'h0, 3'h7, 3'h0, 1'b0, {3'b101, 2'b10});
    lk(48'h9, 4'h0, 3'h7, 3'h4, 1'b1, {3'b000, 2'b01});
    @(posedge mclk);
    ingress <= 3'h1;
    rx_en <= 3'h7;
    $display("t_ports done");
  endtask : t_ports

  task t_persist();
    repeat (300) @(posedge mclk);
    lk(48'hA, 4'h0, 3'h7, 3'h2, 1'b1, {3'b110, 2'b10});
    $display("t_persist done");
  endtask : t_persist

  initial
  begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_entries();
    t_lookup();
    t_masks();
    t_ports();
    t_persist();
    report_and_stop();
  end
endmodule : static_mac_table_lookup_tb_top
